// ==== irq_core_model.sv ====
/* Core model: acks a vector lat+1 cycles after it shows, returns 4 later.
   Assumes the block's pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] irq_vector,
  input wire logic [2:0] lat,
  input wire logic use_return_from_irq,
  output logic irq_ack,
  output logic ret_plain,
  output logic ret_irq
);
  logic [3:0] wt;
  logic [2:0] rc;
  logic [3:0] depth;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {irq_ack, ret_plain, ret_irq, wt, rc, depth} <= '0;
    end else begin
      irq_ack <= 1'b0;
      ret_plain <= 1'b0;
      ret_irq <= 1'b0;
      if (rc != 3'h0) begin
        rc <= rc - 3'h1;
        ret_irq <= rc == 3'h1 && use_return_from_irq;
        ret_plain <= rc == 3'h1 && !use_return_from_irq;
      end else if (irq_vector != 3'h0 && !irq_ack) begin
        wt <= wt + 4'h1;
        if (wt >= {1'b0, lat}) begin
          irq_ack <= 1'b1;
          wt <= 4'h0;
          rc <= 3'h4;
          depth <= depth + 4'h1; // Counter only
          // Depth is never decremented on return, so it counts every ack taken
        end
      end
    end
  end
endmodule // irq_core_model
`default_nettype wire

// ==== tb_tbase_irq.sv ====
/* Self-checking bench for tbase_irq.
   Assumes checker and core model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_tbase_irq;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic sub_clock = 0, ext_irq_edge = 0, mf_source = 0, stack_full = 0, use_return_from_irq = 1;
  logic irq_ack, ret_plain, ret_irq, irq_request, wakeup;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, seed = 32'h302f;
  logic [5:0] serial_events = '0;
  logic [2:0] irq_vector, sel, lat = '0;
  logic [1:0] psc;
  int err_count = 0, comparisons = 0, cyc = 0, wk = 0, w0, t, n;
  always #2.5 pclk = ~pclk;
  tbase_irq #(.TB_WIDTH(11)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sub_clock, .serial_events, .ext_irq_edge, .mf_source, .stack_full, .irq_ack,
    .ret_plain, .ret_irq, .irq_vector, .irq_request, .wakeup);
  irq_core_model core (.pclk, .presetn, .irq_vector, .lat, .use_return_from_irq, .irq_ack, .ret_plain, .ret_irq);
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) sub_clock <= ~sub_clock;
    if (wakeup === 1'b1) wk <= wk + 1;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int period(input logic tb1, input logic [2:0] s, input logic [1:0] p);
    return (1 << (s + (tb1 ? 4 : 0))) * (p == 2'h0 ? 1 : p == 2'h1 ? 4 : 6);
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wait_vec(input logic [2:0] code, input logic want);
    while ((irq_vector === code) != want && n < 4000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task give_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      apb(0, i ? 12'h004 : 12'h000, 0);
      chk("tb_ctrl_rst", 0, rd);
      apb(1, i ? 12'h004 : 12'h000, 32'hffffffff);
      apb(0, i ? 12'h004 : 12'h000, 0);
      chk("tb_ctrl_rw", 32'h87, rd);
      apb(1, i ? 12'h004 : 12'h000, 0);
    end
    apb(0, 12'h018, 0);
    chk("unmapped", 1, {rd[30:0], er});
    for (int i = 0; i < 6; i++) begin
      apb(1, 12'h010, 0);
      serial_events <= 6'h1 << i;
      @(posedge pclk);
      serial_events <= 6'h0;
      apb(0, 12'h010, 0);
      chk("serial_flag", 1, rd);
    end
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      lat <= seed[2:0];
      psc = seed[4:3];
      sel = {~k[0], seed[6:5]};
      apb(1, 12'h000, 0);
      apb(1, 12'h004, 0);
      apb(1, 12'h008, {30'h0, psc});
      apb(1, 12'h010, 0);
      apb(1, k[0] ? 12'h004 : 12'h000, {24'h0, 5'h10, sel});
      apb(1, 12'h00c, k[0] ? 32'h9 : 32'h5);
      n = 0;
      wait_vec(k[0] ? 3'h3 : 3'h2, 1);
      t = n;
      wait_vec(k[0] ? 3'h3 : 3'h2, 0);
      wait_vec(k[0] ? 3'h3 : 3'h2, 1);
      chk("tb_period", period(k[0], sel, psc), n - t);
    end
    apb(1, 12'h004, 0);
    apb(1, 12'h000, 32'h80);
    use_return_from_irq <= 1'b0;
    lat <= 3'h7;
    apb(1, 12'h010, 0);
    apb(1, 12'h00c, 32'h5);
    repeat (300) @(posedge pclk);
    chk("vec_after_ret", 0, irq_vector);
    apb(0, 12'h00c, 0);
    chk("ctrl_after_srv", 32'h4, rd);
    apb(0, 12'h010, 0);
    chk("flag_held", 32'h2, rd);
    stack_full <= 1'b1;
    apb(1, 12'h00c, 32'h5);
    repeat (8) @(posedge pclk);
    chk("vec_full", 0, irq_vector);
    stack_full <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("vec_room", 2, irq_vector);
    apb(1, 12'h000, 0);
    apb(1, 12'h00c, 32'h20);
    apb(1, 12'h010, 0);
    w0 = wk;
    for (int i = 0; i < 2; i++) begin
      mf_source <= 1'b1;
      @(posedge pclk);
      mf_source <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("wake_mf", w0 + 1, wk); // Second pulse finds the flag set
    end
    ext_irq_edge <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("wake_ext", w0 + 2, wk);
    give_verdict();
  end
endmodule // tb_tbase_irq
`default_nettype wire

// ==== tbase_irq.v ====
/*
  Two time base generators plus interrupt request, service, return and
  wake-up logic, with an APB slave for its registers.
  Assumes a core that pulses irq_ack when it takes the vector shown on
  irq_vector, and pulses ret_plain / ret_irq for the two return kinds.
*/
// What this block does
// - Time base zero control bit 7 runs or stops generator zero.
// - Time base zero period is 2 to the field value prescaled ticks.
// - Time base one control bit 7 runs or stops generator one.
// - Time base one period is 2 to field plus four prescaled ticks.
// - Control bits 6 to 3 ignore writes and read zero.
// - Any serial condition raises the one serial request.
// - Serial vector taken only with global, serial enable, stack room, request.
// - Serial service clears its flag and the global enable.
// - Serial service leaves the serial status flags alone.
// - In sleep or idle, any flag rising makes a wake-up; the block has only the sleep bit (control bit 5) and no idle mode.
// - External edges set their flag even with the oscillator stopped; the block samples them on pclk, so pclk must run.
// - Enable bits never affect wake-up.
// - A set flag stays set until serviced or cleared by software.
// - Multi-function service clears only the multi-function flag.
// - Entry pushes only the program counter.
// - Return-from-irq restores the counter and sets the global enable.
// - Plain return restores the counter, global enable stays zero.
// - Prescaler source: system, system over four, or sub clock.
// - Overflow sets its flag; service clears it and the global enable.
`include "tbase_irq_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module tbase_irq #(
  parameter TB_WIDTH = 11
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sub_clock,
  input wire [5:0] serial_events,
  input wire ext_irq_edge,
  input wire mf_source,
  input wire stack_full,
  input wire irq_ack,
  input wire ret_plain,
  input wire ret_irq,
  output reg [2:0] irq_vector,
  output reg irq_request,
  output reg wakeup
);

  reg [7:0] tb0_ctrl_reg;
  reg [7:0] tb1_ctrl_reg;
  reg [1:0] prescaler_source_sel_reg;
  reg [5:0] ctrl_reg;
  reg [`NFLAG-1:0] flag_reg;
  reg [`NFLAG-1:0] flag_next;
  reg [`NFLAG-1:0] flag_prev_reg;
  reg [TB_WIDTH-1:0] cnt0_reg;
  reg [TB_WIDTH-1:0] cnt1_reg;
  reg [1:0] div4_reg;
  reg [1:0] sub_sync_reg;
  reg sub_prev_reg;
  reg [1:0] ext_sync_reg;
  reg ext_prev_reg;
  reg [2:0] vec_next;
  reg [31:0] rdata_next;
  reg slverr_next;
  reg prescaled_clock;
  reg tick0;
  reg tick1;

  wire global_irq_enable = ctrl_reg[`C_GIE];
  wire base_zero_run = tb0_ctrl_reg[`BIT_RUN];
  wire base_one_run = tb1_ctrl_reg[`BIT_RUN];
  wire [2:0] base_zero_period_sel = tb0_ctrl_reg[`SEL_HI:0];
  wire [2:0] base_one_period_sel = tb1_ctrl_reg[`SEL_HI:0];
  wire access = psel && penable && !pready;
  wire wr = access && pwrite;
  wire serial_hit = |serial_events;
  wire ext_rise = ext_sync_reg[1] && !ext_prev_reg;

  // Mask of the low bits that must be all ones at the end of a period
  function [TB_WIDTH-1:0] period_mask;
    input [3:0] expo;
    begin
      period_mask = ~({TB_WIDTH{1'b1}} << expo);
    end
  endfunction

  function overflow;
    input [TB_WIDTH-1:0] cnt;
    input [3:0] expo;
    begin
      overflow = ((cnt & period_mask(expo)) == period_mask(expo));
    end
  endfunction

  // Prescaler tick; the sub clock is slow and asynchronous, so its edge is sampled
  always @* begin
    case (prescaler_source_sel_reg)
      `PSC_SYS: prescaled_clock = 1'b1;
      `PSC_DIV4: prescaled_clock = (div4_reg == `DIV4_LAST);
      default: prescaled_clock = sub_sync_reg[1] && !sub_prev_reg;
    endcase
    tick0 = base_zero_run && prescaled_clock && overflow(cnt0_reg, {1'b0, base_zero_period_sel});
    tick1 = base_one_run && prescaled_clock &&
      overflow(cnt1_reg, {1'b0, base_one_period_sel} + {1'b0, `TB1_SHIFT});
  end

  // Highest priority pending vector; any service needs stack room
  always @* begin
    vec_next = `V_NONE;
    if (global_irq_enable && !stack_full) begin
      if (flag_reg[`F_SER] && ctrl_reg[`C_SER_EN])
        vec_next = `V_SER;
      else if (flag_reg[`F_TB0] && ctrl_reg[`C_TB0_EN])
        vec_next = `V_TB0;
      else if (flag_reg[`F_TB1] && ctrl_reg[`C_TB1_EN])
        vec_next = `V_TB1;
      else if (flag_reg[`F_MF] && ctrl_reg[`C_MF_EN])
        vec_next = `V_MF;
    end
  end

  // Flags: hardware set beats software and service clears
  always @* begin
    flag_next = flag_reg;
    if (wr && paddr == `OFF_IRQ_FLAG)
      flag_next = pwdata[`NFLAG-1:0];
    if (irq_ack) begin
      case (irq_vector)
        `V_SER: flag_next[`F_SER] = 1'b0;
        `V_TB0: flag_next[`F_TB0] = 1'b0;
        `V_TB1: flag_next[`F_TB1] = 1'b0;
        `V_MF: flag_next[`F_MF] = 1'b0;
        default: flag_next = flag_next;
      endcase
    end
    if (serial_hit)
      flag_next[`F_SER] = 1'b1;
    if (tick0)
      flag_next[`F_TB0] = 1'b1;
    if (tick1)
      flag_next[`F_TB1] = 1'b1;
    if (mf_source)
      flag_next[`F_MF] = 1'b1;
    if (ext_rise)
      flag_next[`F_EXT] = 1'b1;
  end

  always @* begin
    rdata_next = 32'h0000_0000;
    slverr_next = 1'b0;
    case (paddr)
      `OFF_TB0_CTRL: rdata_next[7:0] = tb0_ctrl_reg;
      `OFF_TB1_CTRL: rdata_next[7:0] = tb1_ctrl_reg;
      `OFF_PSC_SEL: rdata_next[1:0] = prescaler_source_sel_reg;
      `OFF_IRQ_CTRL: rdata_next[5:0] = ctrl_reg;
      `OFF_IRQ_FLAG: rdata_next[`NFLAG-1:0] = flag_reg;
      `OFF_IRQ_STAT: rdata_next[2:0] = irq_vector;
      default: slverr_next = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb0_ctrl_reg <= `TB_CTRL_RST;
      tb1_ctrl_reg <= `TB_CTRL_RST;
      prescaler_source_sel_reg <= `PSC_SYS;
      ctrl_reg <= 6'h00;
      flag_reg <= {`NFLAG{1'b0}};
      flag_prev_reg <= {`NFLAG{1'b0}};
      cnt0_reg <= {TB_WIDTH{1'b0}};
      cnt1_reg <= {TB_WIDTH{1'b0}};
      div4_reg <= 2'h0;
      sub_sync_reg <= 2'h0;
      sub_prev_reg <= 1'b0;
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_vector <= `V_NONE;
      irq_request <= 1'b0;
      wakeup <= 1'b0;
    end else begin
      sub_sync_reg <= {sub_sync_reg[0], sub_clock};
      sub_prev_reg <= sub_sync_reg[1];
      ext_sync_reg <= {ext_sync_reg[0], ext_irq_edge};
      ext_prev_reg <= ext_sync_reg[1];
      div4_reg <= div4_reg + 2'h1;

      if (!base_zero_run)
        cnt0_reg <= {TB_WIDTH{1'b0}};
      else if (prescaled_clock)
        cnt0_reg <= cnt0_reg + {{(TB_WIDTH-1){1'b0}}, 1'b1};
      if (!base_one_run)
        cnt1_reg <= {TB_WIDTH{1'b0}};
      else if (prescaled_clock)
        cnt1_reg <= cnt1_reg + {{(TB_WIDTH-1){1'b0}}, 1'b1};

      pready <= access;
      if (access) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_next;
        pslverr <= slverr_next;
      end else begin
        pslverr <= 1'b0;
      end
      if (wr) begin
        case (paddr)
          `OFF_TB0_CTRL: tb0_ctrl_reg <= {pwdata[`BIT_RUN], 4'h0, pwdata[`SEL_HI:0]};
          `OFF_TB1_CTRL: tb1_ctrl_reg <= {pwdata[`BIT_RUN], 4'h0, pwdata[`SEL_HI:0]};
          `OFF_PSC_SEL: prescaler_source_sel_reg <= pwdata[1:0];
          default: prescaler_source_sel_reg <= prescaler_source_sel_reg;
        endcase
      end

      // Service and the return-from-irq act on the global enable; only the PC is stacked by the core
      if (irq_ack && irq_vector != `V_NONE)
        ctrl_reg[`C_GIE] <= 1'b0;
      else if (ret_irq)
        ctrl_reg[`C_GIE] <= 1'b1;
      else if (wr && paddr == `OFF_IRQ_CTRL)
        ctrl_reg <= pwdata[5:0];
      // A plain return leaves the global enable as it is

      flag_reg <= flag_next;
      flag_prev_reg <= flag_reg;
      irq_vector <= irq_ack ? `V_NONE : vec_next;
      irq_request <= !irq_ack && (vec_next != `V_NONE);
      // In sleep, any rising flag wakes; enables are not looked at, preset flags cannot rise
      wakeup <= ctrl_reg[`C_SLEEP] && |(flag_reg & ~flag_prev_reg);
    end
  end

endmodule // tbase_irq

`default_nettype wire

// ==== tbase_irq_consts.vh ====
/*
  Constants for the time base and interrupt service block: register offsets,
  field positions, reset values and prescaler selections.
  Assumes inclusion by bare name from the design file.
*/
`ifndef TBASE_IRQ_CONSTS_VH
`define TBASE_IRQ_CONSTS_VH

`define OFF_TB0_CTRL 12'h000
`define OFF_TB1_CTRL 12'h004
`define OFF_PSC_SEL 12'h008
`define OFF_IRQ_CTRL 12'h00c
`define OFF_IRQ_FLAG 12'h010
`define OFF_IRQ_STAT 12'h014

`define BIT_RUN 7
`define SEL_HI 2
`define TB1_SHIFT 3'h4
`define TB_CTRL_RST 8'h00

`define PSC_SYS 2'h0
`define PSC_DIV4 2'h1
`define DIV4_LAST 2'h3

// Control register bits
`define C_GIE 0
`define C_SER_EN 1
`define C_TB0_EN 2
`define C_TB1_EN 3
`define C_MF_EN 4
`define C_SLEEP 5

// Flag register bits
`define F_SER 0
`define F_TB0 1
`define F_TB1 2
`define F_MF 3
`define F_EXT 4
`define NFLAG 5

// Vector codes
`define V_NONE 3'h0
`define V_SER 3'h1
`define V_TB0 3'h2
`define V_TB1 3'h3
`define V_MF 3'h4

`endif

// ==== tbase_irq_sva.sv ====
/* Checker for tbase_irq port timing.
   Assumes the bind below. */
`timescale 1ns/1ps
`default_nettype none
module tbase_irq_sva #(
  parameter TB_WIDTH = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic ret_irq,
  input wire logic [2:0] irq_vector,
  input wire logic irq_request,
  input wire logic wakeup
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_LAT: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready long");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_ERR_RDATA: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
  AST_REQ_LEVEL: assert property (irq_request == (irq_vector != 3'h0)) else $error("request level");
  AST_STACK_BLOCK: assert property (stack_full |=> irq_vector == 3'h0) else $error("vector on full stack");
  AST_ACK_CLEAR: assert property (irq_ack && irq_vector != 3'h0 |=> irq_vector == 3'h0) else $error("ack");
  AST_GIE_HELD: assert property ((irq_ack && irq_vector != 3'h0) ##1 (!ret_irq && !psel) [*4] |->
    irq_vector == 3'h0) else $error("vector without enable");
  AST_WAKE_PULSE: assert property (wakeup |=> !wakeup) else $error("wakeup long");
  COV_TB_ACK: cover property (irq_ack && irq_vector == 3'h3);
  COV_WAKE: cover property (wakeup);
  COV_ERR: cover property (pslverr);
endmodule // tbase_irq_sva
bind tbase_irq tbase_irq_sva #(.TB_WIDTH(TB_WIDTH)) chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .stack_full, .irq_ack, .ret_irq, .irq_vector, .irq_request, .wakeup);
`default_nettype wire
